//--- design/hbl_pkg.sv
// Constants and types for the half-bridge load control block
package hbl_pkg;
  typedef enum logic [1:0] {
    HBL_MODE_6X = 2'h0,
    HBL_MODE_3X = 2'h1,
    HBL_MODE_6X_LIM = 2'h3,
    HBL_MODE_3X_LIM = 2'h2
  } hbl_mode_t;
  localparam int HBL_CLK_HZ = 100_000_000;
  localparam int HBL_PULSE_SLOW_HZ = 20_000;
  localparam int HBL_PULSE_FAST_HZ = 40_000;
  localparam int HBL_PULSE_SLOW_CYC = HBL_CLK_HZ / HBL_PULSE_SLOW_HZ;
  localparam int HBL_PULSE_FAST_CYC = HBL_CLK_HZ / HBL_PULSE_FAST_HZ;
  localparam int HBL_FULL_DUTY_CYC = HBL_PULSE_SLOW_CYC;
  localparam logic [12:0] HBL_CNT_RESET = 13'h0000;
endpackage

//--- design/hbl_half_bridge_ctrl.sv
// Three-phase half-bridge decode with current limit and sense gating
`timescale 1ns/1ps
module hbl_half_bridge_ctrl #(
  parameter int PHASES = 3,
  parameter int PULSE_SLOW_CYC = hbl_pkg::HBL_PULSE_SLOW_CYC,
  parameter int PULSE_FAST_CYC = hbl_pkg::HBL_PULSE_FAST_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [PHASES-1:0] phase_drive_input,
  input wire logic [PHASES-1:0] phase_output_enable,
  input wire hbl_pkg::hbl_mode_t pwm_mode,
  input wire logic pulse_rate_fast,
  input wire logic [PHASES-1:0] load_to_ground,
  input wire logic [PHASES-1:0] current_over_limit,
  output logic [PHASES-1:0] phase_output,
  output logic [PHASES-1:0] phase_output_oe,
  output logic [PHASES-1:0] sense_valid,
  output logic [PHASES-1:0] limit_active,
  output logic refresh_pulse
);
  // Pairing checks need phases 0 and 1; counters are 13 bits wide
  if (PHASES < 2 || PULSE_FAST_CYC < 2 || PULSE_SLOW_CYC < PULSE_FAST_CYC ||
      PULSE_SLOW_CYC > 8191) begin : g_bad_params
    $error("hbl_half_bridge_ctrl: bad parameters");
  end

  logic [12:0] pulse_cnt;
  logic [12:0] pulse_top;
  logic [12:0] high_cnt [PHASES];
  logic lim_mode;
  logic [PHASES-1:0] chop;
  logic [PHASES-1:0] cut;

  assign lim_mode = (pwm_mode == hbl_pkg::HBL_MODE_6X_LIM) ||
                    (pwm_mode == hbl_pkg::HBL_MODE_3X_LIM);
  assign pulse_top = pulse_rate_fast ? 13'(PULSE_FAST_CYC - 1) :
                     13'(PULSE_SLOW_CYC - 1);

  // Internal refresh timer for full-duty inputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse_cnt <= hbl_pkg::HBL_CNT_RESET;
      refresh_pulse <= 1'b0;
    end else begin
      refresh_pulse <= (pulse_cnt >= pulse_top);
      pulse_cnt <= (pulse_cnt >= pulse_top) ? hbl_pkg::HBL_CNT_RESET :
                   pulse_cnt + 13'h0001;
    end
  end

  // Cycles since the last refresh pulse, for the spacing check
  logic [12:0] gap_cnt;
  always_ff @(posedge sys_clk) begin
    if (rst || refresh_pulse) begin
      gap_cnt <= hbl_pkg::HBL_CNT_RESET;
    end else if (gap_cnt != 13'h1FFF) begin
      gap_cnt <= gap_cnt + 13'h0001;
    end
  end

  for (genvar p = 0; p < PHASES; p++) begin : g_ph
    // Counts cycles the input has held high
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        high_cnt[p] <= hbl_pkg::HBL_CNT_RESET;
      end else if (phase_output_enable[p] && phase_drive_input[p]) begin
        if (high_cnt[p] != 13'h1FFF) begin
          high_cnt[p] <= high_cnt[p] + 13'h0001;
        end
      end else begin
        high_cnt[p] <= hbl_pkg::HBL_CNT_RESET;
      end
    end

    // Chop latch: set on overcurrent, released by input low or by a refresh once the input has been high for a full period
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        chop[p] <= 1'b0;
      end else if (!lim_mode || load_to_ground[p] ||
                   !phase_output_enable[p]) begin
        chop[p] <= 1'b0;
      end else if (current_over_limit[p] && phase_drive_input[p]) begin
        chop[p] <= 1'b1;
      end else if (!phase_drive_input[p] ||
                   (refresh_pulse && high_cnt[p] >= pulse_top)) begin
        chop[p] <= 1'b0;
      end
    end

    // Output stage, registered
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        phase_output[p] <= 1'b0;
        phase_output_oe[p] <= 1'b0;
        sense_valid[p] <= 1'b0;
      end else begin
        phase_output_oe[p] <= phase_output_enable[p];
        phase_output[p] <= phase_output_enable[p] &&
                           phase_drive_input[p] && !cut[p];
        sense_valid[p] <= phase_output_enable[p] && !load_to_ground[p] &&
                          !(phase_drive_input[p] && !cut[p]);
      end
    end
    // Gate with mode and load so a stale latch never cuts the output
    assign cut[p] = chop[p] && lim_mode && !load_to_ground[p];
    assign limit_active[p] = chop[p];

    property p_enabled_follow;
      @(posedge sys_clk) disable iff (rst)
      (phase_output_enable[p] && !lim_mode) |=>
        phase_output_oe[p] && (phase_output[p] == $past(phase_drive_input[p]));
    endproperty
    a_enabled_follow: assert property (p_enabled_follow)
      else $error("enabled phase output does not follow input");

    property p_disabled_z;
      @(posedge sys_clk) disable iff (rst)
      !phase_output_enable[p] |=> !phase_output_oe[p] && !phase_output[p];
    endproperty
    a_disabled_z: assert property (p_disabled_z)
      else $error("disabled phase still driven");

    property p_no_limit_plain;
      @(posedge sys_clk) disable iff (rst)
      !lim_mode |=> !limit_active[p];
    endproperty
    a_no_limit_plain: assert property (p_no_limit_plain)
      else $error("limit active outside limit modes");

    property p_sense_low_side;
      @(posedge sys_clk) disable iff (rst)
      sense_valid[p] |-> phase_output_oe[p] && !phase_output[p];
    endproperty
    a_sense_low_side: assert property (p_sense_low_side)
      else $error("sense valid while low side off");

    property p_ground_load;
      @(posedge sys_clk) disable iff (rst)
      load_to_ground[p] |=> !sense_valid[p] && !limit_active[p];
    endproperty
    a_ground_load: assert property (p_ground_load)
      else $error("ground load given feedback or limit");

    property p_chop_cuts;
      @(posedge sys_clk) disable iff (rst)
      (lim_mode && phase_output_enable[p] && !load_to_ground[p] &&
       phase_drive_input[p] && current_over_limit[p]) ##1
      (lim_mode && phase_output_enable[p] && !load_to_ground[p])
        |=> !phase_output[p];
    endproperty
    a_chop_cuts: assert property (p_chop_cuts)
      else $error("overcurrent did not cut the high side");

    property p_low_side_sense;
      @(posedge sys_clk) disable iff (rst)
      (phase_output_enable[p] && !phase_drive_input[p] &&
       !load_to_ground[p]) |=> sense_valid[p];
    endproperty
    a_low_side_sense: assert property (p_low_side_sense)
      else $error("low side conducting but sense not valid");

    property p_input_low_frees;
      @(posedge sys_clk) disable iff (rst)
      !phase_drive_input[p] |=> !limit_active[p];
    endproperty
    a_input_low_frees: assert property (p_input_low_frees)
      else $error("limit held after input went low");

    property p_chop_holds;
      @(posedge sys_clk) disable iff (rst)
      (limit_active[p] && lim_mode && phase_output_enable[p] &&
       phase_drive_input[p] && !load_to_ground[p] && !refresh_pulse)
        |=> limit_active[p];
    endproperty
    a_chop_holds: assert property (p_chop_holds)
      else $error("limit released without refresh");

    property p_full_duty_release;
      @(posedge sys_clk) disable iff (rst)
      (limit_active[p] && refresh_pulse && !current_over_limit[p] &&
       high_cnt[p] >= pulse_top) |=> !limit_active[p];
    endproperty
    a_full_duty_release: assert property (p_full_duty_release)
      else $error("full-duty refresh did not release the limit");
  end

  property p_pulse_period;
    @(posedge sys_clk) disable iff (rst)
    refresh_pulse |-> gap_cnt >= 13'(PULSE_FAST_CYC - 1) &&
      gap_cnt <= 13'(PULSE_SLOW_CYC);
  endproperty
  a_pulse_period: assert property (p_pulse_period)
    else $error("refresh pulse too frequent");

  property p_pulse_single;
    @(posedge sys_clk) disable iff (rst)
    refresh_pulse |=> !refresh_pulse;
  endproperty
  a_pulse_single: assert property (p_pulse_single)
    else $error("refresh pulse longer than one cycle");

  property p_pair_forward;
    @(posedge sys_clk) disable iff (rst)
    (&phase_output_enable[1:0] && phase_drive_input[1:0] == 2'h1 &&
     !lim_mode) |=> phase_output[1:0] == 2'h1;
  endproperty
  a_pair_forward: assert property (p_pair_forward)
    else $error("forward pair not decoded");

  property p_pair_reverse;
    @(posedge sys_clk) disable iff (rst)
    (&phase_output_enable[1:0] && phase_drive_input[1:0] == 2'h2 &&
     !lim_mode) |=> phase_output[1:0] == 2'h2;
  endproperty
  a_pair_reverse: assert property (p_pair_reverse)
    else $error("reverse pair not decoded");

  c_forward: cover property (@(posedge sys_clk) disable iff (rst)
    phase_output_oe[1:0] == 2'h3 && phase_output[1:0] == 2'h1);
  c_reverse: cover property (@(posedge sys_clk) disable iff (rst)
    phase_output_oe[1:0] == 2'h3 && phase_output[1:0] == 2'h2);
  c_chop: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(limit_active[0]));
  c_refresh: cover property (@(posedge sys_clk) disable iff (rst)
    refresh_pulse && limit_active[0]);
  c_three_loads: cover property (@(posedge sys_clk) disable iff (rst)
    &phase_output_oe && lim_mode);
endmodule // hbl_half_bridge_ctrl

//--- dv/hbl_mcu_model.sv
// Controller model driving per-phase input and enable pins
`timescale 1ns/1ps
module hbl_mcu_model (
  input wire logic sys_clk,
  input wire logic [2:0] bridge_cmd,
  input wire logic [1:0] sol_cmd,
  output logic [2:0] phase_drive_input = 3'h0,
  output logic [2:0] phase_output_enable = 3'h0
);
  // Phases 0/1 as H-bridge: fwd, rev, low brake, high brake, coast
  always_ff @(posedge sys_clk) begin
    case (bridge_cmd)
      3'h0: {phase_output_enable[1:0], phase_drive_input[1:0]} <= 4'hD;
      3'h1: {phase_output_enable[1:0], phase_drive_input[1:0]} <= 4'hE;
      3'h2: {phase_output_enable[1:0], phase_drive_input[1:0]} <= 4'hC;
      3'h3: {phase_output_enable[1:0], phase_drive_input[1:0]} <= 4'hF;
      default: begin
        // Coast: inputs are don't-care, so keep them moving
        phase_output_enable[1:0] <= 2'h0;
        phase_drive_input[1:0] <= ~phase_drive_input[1:0];
      end
    endcase
    {phase_output_enable[2], phase_drive_input[2]} <= sol_cmd;
  end
endmodule // hbl_mcu_model

//--- dv/test_half_bridge_load_control.sv
// Self-checking bench for the half-bridge load control block
`timescale 1ns/1ps
module test_half_bridge_load_control;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] bridge_cmd = 3'h4;
  logic [1:0] sol_cmd = 2'h0;
  hbl_pkg::hbl_mode_t pwm_mode = hbl_pkg::HBL_MODE_6X;
  logic pulse_rate_fast = 1'b0;
  logic [2:0] load_to_ground = 3'h0;
  logic [2:0] current_over_limit = 3'h0;
  logic [2:0] phase_drive_input, phase_output_enable, phase_output;
  logic [2:0] phase_output_oe, sense_valid, limit_active;
  logic refresh_pulse;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  hbl_mcu_model u_hbl_mcu_model (.sys_clk(sys_clk), .bridge_cmd(bridge_cmd),
    .sol_cmd(sol_cmd), .phase_drive_input(phase_drive_input),
    .phase_output_enable(phase_output_enable));
  hbl_half_bridge_ctrl #(.PULSE_SLOW_CYC(20), .PULSE_FAST_CYC(10))
    u_hbl_half_bridge_ctrl (.sys_clk(sys_clk), .rst(rst),
    .phase_drive_input(phase_drive_input),
    .phase_output_enable(phase_output_enable), .pwm_mode(pwm_mode),
    .pulse_rate_fast(pulse_rate_fast), .load_to_ground(load_to_ground),
    .current_over_limit(current_over_limit), .phase_output(phase_output),
    .phase_output_oe(phase_output_oe), .sense_valid(sense_valid),
    .limit_active(limit_active), .refresh_pulse(refresh_pulse));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic t_bridge();
    logic [1:0] outs [5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h0};
    for (int c = 0; c < 5; c++) begin
      tick(1);
      bridge_cmd <= 3'(c);
      tick(3); #1;
      chk({phase_output_oe, phase_output}, {1'b0, (c < 4) ? 2'h3 : 2'h0,
        1'b0, outs[c]});
    end
    $display("t_bridge done");
  endtask
  task automatic t_sol();
    tick(1);
    pwm_mode <= hbl_pkg::HBL_MODE_3X_LIM;
    for (int s = 0; s < 5; s++) begin
      tick(1);
      sol_cmd <= (s == 4) ? 2'h2 : 2'(s);
      load_to_ground[2] <= (s == 4);
      tick(3);
      #1;
      chk({phase_output_oe[2], phase_output[2], sense_valid[2]},
        {s[1] || s == 4, s[1] & s[0], s == 2});
    end
    $display("t_sol done");
  endtask
  task automatic t_limit();
    hbl_pkg::hbl_mode_t m;
    logic lim;
    for (int i = 0; i < 5; i++) begin
      m = (i < 4) ? hbl_pkg::hbl_mode_t'(i[1:0]) : hbl_pkg::HBL_MODE_6X_LIM;
      lim = (m == hbl_pkg::HBL_MODE_6X_LIM || m == hbl_pkg::HBL_MODE_3X_LIM)
        && i < 4;
      tick(1);
      bridge_cmd <= 3'h0;
      pwm_mode <= m;
      load_to_ground[0] <= (i == 4);
      tick(3);
      current_over_limit[0] <= 1'b1;
      tick(1);
      #1;
      chk({limit_active[0], phase_output[0]}, {lim, 1'b1});
      tick(1);
      #1;
      chk({limit_active[0], phase_output[0]}, {lim, ~lim});
      tick(1);
      {current_over_limit[0], bridge_cmd} <= {1'b0, 3'h2};
      tick(3);
    end
    $display("t_limit done");
  endtask
  task automatic t_refresh();
    int n;
    for (int f = 0; f < 2; f++) begin
      tick(1);
      pulse_rate_fast <= f[0];
      n = 0;
      do begin
        tick(1);
        #1;
        n++;
      end while (refresh_pulse !== 1'b1 && n < 99);
      n = 0;
      do begin
        tick(1);
        #1;
        n++;
      end while (refresh_pulse !== 1'b1 && n < 99);
      chk(8'(n), f ? 8'h0A : 8'h14);
    end
    // Full duty: one overcurrent, input held high, refresh must free it
    tick(1);
    bridge_cmd <= 3'h0;
    load_to_ground[0] <= 1'b0;
    tick(3);
    current_over_limit[0] <= 1'b1;
    tick(1);
    current_over_limit[0] <= 1'b0;
    n = 0;
    do begin
      tick(1);
      #1;
      n++;
    end while (limit_active[0] === 1'b1 && n < 99);
    chk(8'(n > 5 && n <= 20), 8'h01);
    tick(1);
    #1;
    chk(8'(phase_output[0]), 8'h01);
    $display("t_refresh done");
  endtask
  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    tick(2);
    rst <= 1'b0;
    t_bridge();
    t_sol();
    t_limit();
    pwm_mode <= hbl_pkg::HBL_MODE_6X_LIM;
    t_refresh();
    print_verdict();
  end
endmodule // test_half_bridge_load_control
